// ### fspc_defs.vh
// constants for the flash self-programming control block
`ifndef FSPC_DEFS_VH
`define FSPC_DEFS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define FSPC_CTRL_IDX 8'h37
`define FSPC_CTRL_ADDR 12'h0DC
`define FSPC_ROUT_ADDR 12'h0E0
`define FSPC_FUSE_ADDR 12'h0E4
`define FSPC_CTRL_RST 8'h00

// ----------------------------------------
// control bit positions
// ----------------------------------------
`define FSPC_B_EN 0
`define FSPC_B_ERS 1
`define FSPC_B_WRT 2
`define FSPC_B_LCK 3
`define FSPC_B_RRE 4
`define FSPC_B_BUSY 6
`define FSPC_B_IE 7

// ----------------------------------------
// command patterns, low five bits
// ----------------------------------------
`define FSPC_CMD_RRE 5'h11
`define FSPC_CMD_LCK 5'h09
`define FSPC_CMD_WRT 5'h05
`define FSPC_CMD_ERS 5'h03
`define FSPC_CMD_FILL 5'h01

// ----------------------------------------
// flash geometry
// ----------------------------------------
`define FSPC_PC_W 14
`define FSPC_WORD_W 6
`define FSPC_PAGE_W 8
`define FSPC_NO_READ_WHILE_WRITE_REGION_START 14'h3800
`define FSPC_BOOT_256 14'h3F00
`define FSPC_BOOT_512 14'h3E00
`define FSPC_BOOT_1K 14'h3C00
`define FSPC_BOOT_2K 14'h3800

// ----------------------------------------
// timing
// ----------------------------------------
`define FSPC_WIN_CYC 3'd4
`define FSPC_LPM_CYC 3'd3
`define FSPC_CLK_MHZ 200
`define FSPC_PROG_MIN_US 3700
`define FSPC_PROG_MAX_US 4500
`define FSPC_PROG_MIN_CYC (`FSPC_PROG_MIN_US * `FSPC_CLK_MHZ)
`define FSPC_PROG_MAX_CYC (`FSPC_PROG_MAX_US * `FSPC_CLK_MHZ)

`endif

// ### fspc_ctrl.v
// flash self-programming control unit with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defs.vh"

module fspc_ctrl #(
    parameter integer PROG_MIN_CYC = `FSPC_PROG_MIN_CYC,
    parameter integer PROG_MAX_CYC = `FSPC_PROG_MAX_CYC
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // core side
    input wire global_irq_en,
    input wire store_strobe,
    input wire load_strobe,
    input wire [15:0] zptr,
    input wire [7:0] data_lo,
    input wire [7:0] data_hi,
    input wire boot_size_sel_hi,
    input wire boot_size_sel_lo,
    input wire [7:0] lock_bits_in,
    input wire [7:0] fuse_bits_in,
    output reg [7:0] load_data_r,
    output reg load_valid_r,
    output wire store_ready_irq,
    output wire core_stall,
    output wire rwsec_blocked,
    output wire [13:0] boot_start,
    // flash array side
    output reg buf_wr_r,
    output reg [5:0] buf_word_r,
    output reg [15:0] buf_data_r,
    output reg buf_discard_r,
    output reg erase_start_r,
    output reg write_start_r,
    output reg lock_start_r,
    output reg [7:0] page_r,
    output reg [7:0] lock_data_r,
    input wire flash_done
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_ARMED = 2'd1;
    localparam ST_PROG = 2'd2;

    reg [1:0] state_r;
    reg [4:0] cmd_r;
    reg ie_r;
    reg busy_r;
    reg no_read_while_write_region_op_r;
    reg loading_r;
    reg [2:0] win_r;
    reg [2:0] lpm_win_r;
    reg [31:0] prog_cnt_r;
    reg [31:0] prog_cnt_nxt;

    wire acc = psel & penable;
    wire ctrl_wr = acc & pwrite & (paddr == `FSPC_CTRL_ADDR);
    wire [4:0] wcmd = pwdata[4:0];
    wire cmd_ok = (wcmd == `FSPC_CMD_RRE) | (wcmd == `FSPC_CMD_LCK) |
                  (wcmd == `FSPC_CMD_WRT) | (wcmd == `FSPC_CMD_ERS) |
                  (wcmd == `FSPC_CMD_FILL);
    wire enable_bit = (state_r != ST_IDLE);
    wire prog_busy = (state_r == ST_PROG);

    // page number from pointer, bit 15 ignored
    wire [7:0] zpage = zptr[14:7];
    wire [5:0] zword = zptr[6:1];
    wire [13:0] zpc = {zpage, zword};
    wire page_no_read_while_write_region = (zpc >= `FSPC_NO_READ_WHILE_WRITE_REGION_START);

    // ----------------------------------------
    // boot region
    // ----------------------------------------
    reg [13:0] boot_start_c;
    always @* begin
        case ({boot_size_sel_hi, boot_size_sel_lo})
            2'b11: boot_start_c = `FSPC_BOOT_256;
            2'b10: boot_start_c = `FSPC_BOOT_512;
            2'b01: boot_start_c = `FSPC_BOOT_1K;
            default: boot_start_c = `FSPC_BOOT_2K;
        endcase
    end
    assign boot_start = boot_start_c;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    wire store_go = store_strobe & (state_r == ST_ARMED);
    wire done_ok = flash_done & (prog_cnt_r >= PROG_MIN_CYC);
    wire done_lim = (prog_cnt_r >= PROG_MAX_CYC - 1);

    always @* begin
        prog_cnt_nxt = prog_busy ? prog_cnt_r + 32'd1 : 32'd0;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            cmd_r <= 5'h00;
            ie_r <= 1'b0;
            busy_r <= 1'b0;
            no_read_while_write_region_op_r <= 1'b0;
            loading_r <= 1'b0;
            win_r <= 3'd0;
            lpm_win_r <= 3'd0;
            prog_cnt_r <= 32'd0;
            buf_wr_r <= 1'b0;
            buf_word_r <= 6'h00;
            buf_data_r <= 16'h0000;
            buf_discard_r <= 1'b0;
            erase_start_r <= 1'b0;
            write_start_r <= 1'b0;
            lock_start_r <= 1'b0;
            page_r <= 8'h00;
            lock_data_r <= 8'hFF;
            load_data_r <= 8'h00;
            load_valid_r <= 1'b0;
        end else begin
            buf_wr_r <= 1'b0;
            buf_discard_r <= 1'b0;
            erase_start_r <= 1'b0;
            write_start_r <= 1'b0;
            lock_start_r <= 1'b0;
            load_valid_r <= 1'b0;
            prog_cnt_r <= prog_cnt_nxt;
            if (lpm_win_r != 3'd0) begin
                lpm_win_r <= lpm_win_r - 3'd1;
            end
            if (ctrl_wr) begin
                ie_r <= pwdata[`FSPC_B_IE];
            end
            case (state_r)
                ST_IDLE: begin
                    if (ctrl_wr && cmd_ok) begin
                        state_r <= ST_ARMED;
                        cmd_r <= wcmd;
                        win_r <= `FSPC_WIN_CYC;
                        if (wcmd == `FSPC_CMD_LCK) begin
                            lpm_win_r <= `FSPC_LPM_CYC;
                        end
                        if (wcmd == `FSPC_CMD_RRE && loading_r) begin
                            loading_r <= 1'b0;
                            buf_discard_r <= 1'b1;
                        end
                    end
                end
                ST_ARMED: begin
                    if (store_go) begin
                        case (cmd_r)
                            `FSPC_CMD_FILL: begin
                                buf_wr_r <= 1'b1;
                                buf_word_r <= zword;
                                buf_data_r <= {data_hi, data_lo};
                                loading_r <= 1'b1;
                                busy_r <= 1'b0;
                                state_r <= ST_IDLE;
                                cmd_r <= 5'h00;
                            end
                            `FSPC_CMD_RRE: begin
                                busy_r <= 1'b0;
                                state_r <= ST_IDLE;
                                // command bits must not linger in the status view
                                cmd_r <= 5'h00;
                            end
                            `FSPC_CMD_LCK: begin
                                lock_start_r <= 1'b1;
                                lock_data_r <= data_lo;
                                no_read_while_write_region_op_r <= 1'b0;
                                state_r <= ST_PROG;
                            end
                            `FSPC_CMD_WRT: begin
                                write_start_r <= 1'b1;
                                page_r <= zpage;
                                loading_r <= 1'b0;
                                busy_r <= busy_r | ~page_no_read_while_write_region;
                                no_read_while_write_region_op_r <= page_no_read_while_write_region;
                                state_r <= ST_PROG;
                            end
                            default: begin
                                erase_start_r <= 1'b1;
                                page_r <= zpage;
                                busy_r <= busy_r | ~page_no_read_while_write_region;
                                no_read_while_write_region_op_r <= page_no_read_while_write_region;
                                state_r <= ST_PROG;
                            end
                        endcase
                    end else if (win_r == 3'd1) begin
                        state_r <= ST_IDLE;
                        cmd_r <= 5'h00;
                    end else begin
                        win_r <= win_r - 3'd1;
                    end
                end
                ST_PROG: begin
                    // a lost completion must not hang the core forever
                    if (done_ok || done_lim) begin
                        state_r <= ST_IDLE;
                        cmd_r <= 5'h00;
                        no_read_while_write_region_op_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
            if (load_strobe) begin
                load_valid_r <= 1'b1;
                if (lpm_win_r != 3'd0 && cmd_r == `FSPC_CMD_LCK && state_r == ST_ARMED) begin
                    // raw bits pass: programmed reads zero
                    load_data_r <= zptr[0] ? fuse_bits_in : lock_bits_in;
                end else begin
                    load_data_r <= 8'hFF;
                end
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign store_ready_irq = ie_r & global_irq_en & ~enable_bit;
    assign core_stall = prog_busy & no_read_while_write_region_op_r;
    assign rwsec_blocked = busy_r;

    // ----------------------------------------
    // apb read
    // ----------------------------------------
    wire [7:0] ctrl_view = {ie_r, busy_r, 1'b0, cmd_r[4:1], enable_bit};
    reg [31:0] rdata_c;
    reg err_c;
    always @* begin
        rdata_c = 32'h00000000;
        err_c = 1'b0;
        case (paddr)
            `FSPC_CTRL_ADDR: rdata_c = {24'h000000, ctrl_view};
            `FSPC_ROUT_ADDR: rdata_c = {18'h00000, boot_start_c};
            `FSPC_FUSE_ADDR: rdata_c = {16'h0000, fuse_bits_in, lock_bits_in};
            default: err_c = 1'b1;
        endcase
    end
    assign prdata = (acc & ~pwrite) ? rdata_c : 32'h00000000;
    assign pready = 1'b1;
    assign pslverr = acc & err_c;

endmodule // fspc_ctrl
`default_nettype wire

// ### fspc_ctrl_checker.sv
// assertions on the ports of the flash self-programming control block
`timescale 1ns/1ps
`default_nettype none
module fspc_ctrl_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // core side
    input wire logic global_irq_en,
    input wire logic store_strobe,
    input wire logic load_strobe,
    input wire logic [15:0] zptr,
    input wire logic [7:0] data_lo,
    input wire logic [7:0] data_hi,
    input wire logic load_valid_r,
    input wire logic store_ready_irq,
    input wire logic core_stall,
    // flash array side
    input wire logic buf_wr_r,
    input wire logic [5:0] buf_word_r,
    input wire logic [15:0] buf_data_r,
    input wire logic erase_start_r,
    input wire logic write_start_r,
    input wire logic lock_start_r,
    input wire logic [7:0] page_r,
    input wire logic [7:0] lock_data_r
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_fill_cause: assert property (buf_wr_r |-> $past(store_strobe)
        && buf_data_r == $past({data_hi, data_lo})) else $error("fill data wrong");
    a_fill_word: assert property (buf_wr_r |-> buf_word_r == $past(zptr[6:1]))
        else $error("fill word wrong");
    a_page_sel: assert property ((erase_start_r || write_start_r) |->
        page_r == $past(zptr[14:7])) else $error("page number wrong");
    a_lock_data: assert property (lock_start_r |-> lock_data_r == $past(data_lo))
        else $error("lock data wrong");
    a_load_answer: assert property (load_strobe |=> load_valid_r ##1 !load_valid_r)
        else $error("load answer missing");
    a_irq_gate: assert property (store_ready_irq |-> global_irq_en)
        else $error("irq without global flag");
    a_stall_region: assert property (core_stall |-> page_r >= 8'hE0)
        else $error("stall outside region");
    a_erase_once: assert property (erase_start_r |=> !erase_start_r [*8])
        else $error("erase restarted");
endmodule // fspc_ctrl_checker
`default_nettype wire

// ### fspc_core_model.sv
// behavioural model of the core issuing store and load strobes
`timescale 1ns/1ps
`default_nettype none
module fspc_core_model (
    // clock
    input wire logic pclk,
    // strobes and operands
    output logic store_strobe,
    output logic load_strobe,
    output logic [15:0] zptr,
    output logic [7:0] data_lo,
    output logic [7:0] data_hi
);
    initial {store_strobe, load_strobe, zptr, data_lo, data_hi} = '0;
    // operands are dead after the strobe, so they turn to garbage
    task automatic issue(input logic s, input logic [15:0] z, input logic [15:0] d);
        store_strobe <= s;
        load_strobe <= !s;
        zptr <= s ? {z[15:1], 1'b0} : z;
        {data_hi, data_lo} <= d;
        @(posedge pclk);
        store_strobe <= 1'b0;
        load_strobe <= 1'b0;
        zptr <= ~z;
        {data_hi, data_lo} <= ~d;
        @(posedge pclk);
    endtask
endmodule // fspc_core_model
`default_nettype wire

// ### fspc_ctrl_bench.sv
// self-checking testbench for the flash self-programming control block
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defs.vh"
module fspc_ctrl_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, gie = 0, bsh = 0, bsl = 0;
    logic done = 0, no_read_while_write_region_exp = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rs = 32'd19274, r;
    logic [7:0] lock_in = 8'hA5, fuse_in = 8'h3C;
    logic [7:0] bad[3] = '{8'h87, 8'h90, 8'h9F};
    logic [35:0] expq[$];
    int err_count = 0, cmp_count = 0;
    wire [31:0] prdata;
    wire pready, pslv, irq_o, stall_o, blk_o, bdis, st, ld, lval, bw, es, ws, ls;
    wire [15:0] zp, bdat;
    wire [7:0] dl, dh, ldat, pg, lkd;
    wire [5:0] bwd;
    wire [13:0] bst;
    fspc_ctrl #(.PROG_MIN_CYC(10), .PROG_MAX_CYC(80)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslv),
        .global_irq_en(gie), .store_strobe(st), .load_strobe(ld), .zptr(zp), .data_lo(dl),
        .data_hi(dh), .boot_size_sel_hi(bsh), .boot_size_sel_lo(bsl), .lock_bits_in(lock_in),
        .fuse_bits_in(fuse_in), .load_data_r(ldat), .load_valid_r(lval),
        .store_ready_irq(irq_o), .core_stall(stall_o), .rwsec_blocked(blk_o), .boot_start(bst),
        .buf_wr_r(bw), .buf_word_r(bwd), .buf_data_r(bdat), .buf_discard_r(bdis),
        .erase_start_r(es), .write_start_r(ws), .lock_start_r(ls), .page_r(pg),
        .lock_data_r(lkd), .flash_done(done));
    fspc_core_model core_u (.pclk(pclk), .store_strobe(st), .load_strobe(ld), .zptr(zp),
        .data_lo(dl), .data_hi(dh));
    initial forever #2.5 pclk = ~pclk;
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic fail(input string m);
        err_count++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    task automatic chk(input logic [35:0] g);
        cmp_count++;
        if (expq.size() == 0)
            fail("unexpected result");
        else if (expq.pop_front() !== g)
            fail("result differs");
    endtask
    task automatic ex(input logic [3:0] k, input logic [31:0] v);
        expq.push_back({k, v});
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail("bus wait expired");
            stop_test();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        apb(1'b1, `FSPC_CTRL_ADDR, {24'h0, d});
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        ex(4'h0, e);
        apb(1'b0, a, 32'h0);
    endtask
    // status pins are noted first, the monitor pops them before the read word
    task automatic rdc(input logic [7:0] e);
        ex(4'h8, {29'h0, e[7] & gie & ~e[0], no_read_while_write_region_exp, e[6]});
        rd(`FSPC_CTRL_ADDR, {24'h0, e});
    endtask
    // programming time lies between the shortened minimum and maximum
    task automatic done_op();
        repeat (20) @(posedge pclk);
        done <= 1'b1;
        @(posedge pclk);
        done <= 1'b0;
        @(posedge pclk);
    endtask
    always @(posedge pclk) if (presetn) begin
        if (psel && penable && !pwrite) begin
            if (paddr == `FSPC_CTRL_ADDR) chk({4'h8, 29'h0, irq_o, stall_o, blk_o});
            if (paddr == `FSPC_ROUT_ADDR) chk({4'h9, 18'h0, bst});
            chk({pslv ? 4'h6 : 4'h0, prdata});
        end
        if (bw) chk({4'h1, 10'h0, bwd, bdat});
        if (es) chk({4'h2, 24'h0, pg});
        if (ws) chk({4'h3, 24'h0, pg});
        if (ls) chk({4'h4, 24'h0, lkd});
        if (lval) chk({4'h5, 24'h0, ldat});
        if (bdis) chk({4'h7, 32'h0});
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fail("run time expired");
        stop_test();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(8'h00);
        ex(4'h6, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        rd(`FSPC_FUSE_ADDR, {16'h0, fuse_in, lock_in});
        for (int i = 0; i < 4; i++) begin
            {bsh, bsl} <= i[1:0];
            @(posedge pclk);
            ex(4'h9, 32'h4000 - (32'h100 << (3 - i)));
            rd(`FSPC_ROUT_ADDR, 32'h4000 - (32'h100 << (3 - i)));
        end
        gie <= 1'b1;
        for (int j = 0; j < 3; j++) begin
            wr(8'h81);
            r = rnd();
            ex(4'h1, {10'h0, r[6:1], r[31:16]});
            core_u.issue(1'b1, r[15:0], r[31:16]);
        end
        // store on the last edge of the window is still taken
        wr(8'h81);
        repeat (2) @(posedge pclk);
        ex(4'h1, {10'h0, 6'h01, 16'hBEEF});
        core_u.issue(1'b1, 16'h0002, 16'hBEEF);
        // one edge later the window has lapsed
        wr(8'h01);
        repeat (3) @(posedge pclk);
        core_u.issue(1'b1, 16'h0002, 16'h1234);
        rdc(8'h00);
        foreach (bad[k]) begin
            wr(bad[k]);
            rdc(8'h80);
        end
        wr(8'h83);
        ex(4'h2, 32'h10);
        core_u.issue(1'b1, 16'h8800, 16'hFFFF);
        rdc(8'hC3);
        wr(8'h91);
        core_u.issue(1'b1, 16'h0000, 16'h0000);
        rdc(8'hC3);
        done_op();
        rdc(8'hC0);
        ex(4'h7, 32'h0);
        wr(8'h91);
        core_u.issue(1'b1, 16'h0000, 16'h0000);
        rdc(8'h80);
        wr(8'h85);
        ex(4'h3, 32'hE0);
        core_u.issue(1'b1, 16'h7000, 16'h5555);
        no_read_while_write_region_exp = 1'b1;
        rdc(8'h85);
        done_op();
        no_read_while_write_region_exp = 1'b0;
        rdc(8'h80);
        // early completion is ignored, the limit then ends the erase
        wr(8'h83);
        ex(4'h2, 32'h1);
        core_u.issue(1'b1, 16'h0080, 16'h0000);
        done <= 1'b1;
        @(posedge pclk);
        done <= 1'b0;
        rdc(8'hC3);
        repeat (80) @(posedge pclk);
        rdc(8'hC0);
        wr(8'h91);
        core_u.issue(1'b1, 16'h0000, 16'h0000);
        rdc(8'h80);
        for (int i = 0; i < 2; i++) begin
            wr(8'h89);
            ex(4'h5, i ? fuse_in : lock_in);
            core_u.issue(1'b0, i[15:0], 16'h0000);
            repeat (4) @(posedge pclk);
        end
        ex(4'h5, 32'hFF);
        core_u.issue(1'b0, 16'h0000, 16'h0000);
        wr(8'h89);
        r = rnd();
        ex(4'h4, r[7:0]);
        core_u.issue(1'b1, r[31:16], r[15:0]);
        done_op();
        rdc(8'h80);
        if (expq.size() != 0) fail("results missing");
        stop_test();
    end
endmodule // fspc_ctrl_bench
bind fspc_ctrl fspc_ctrl_checker chk_u (.pclk(pclk), .presetn(presetn),
    .global_irq_en(global_irq_en), .store_strobe(store_strobe), .load_strobe(load_strobe),
    .zptr(zptr), .data_lo(data_lo), .data_hi(data_hi), .load_valid_r(load_valid_r),
    .store_ready_irq(store_ready_irq), .core_stall(core_stall), .buf_wr_r(buf_wr_r),
    .buf_word_r(buf_word_r), .buf_data_r(buf_data_r), .erase_start_r(erase_start_r),
    .write_start_r(write_start_r), .lock_start_r(lock_start_r), .page_r(page_r),
    .lock_data_r(lock_data_r));
`default_nettype wire
